// >>> verilog/art_defines.vh
// Register offsets, field positions and reset values of the auto-reload timer.
`ifndef ART_DEFINES_VH
`define ART_DEFINES_VH
`define ART_ADDR_PRESCALE 8'hd2
`define ART_ADDR_MODE 8'hd5
`define ART_ADDR_STATUS 8'hd6
`define ART_ADDR_CLKSEL 8'hd7
`define ART_ADDR_RELOAD 8'hd9
`define ART_ADDR_COMPARE 8'hda
`define ART_ADDR_LOAD 8'hdb
`define ART_MODE_RESET 8'h00
`define ART_BIT_LOAD 7
`define ART_BIT_ENABLE 6
`define ART_BIT_PWM_OUTPUT_ENABLE 5
`define ART_BIT_EIE 4
`define ART_BIT_MATCH_IRQ_ENABLE 3
`define ART_BIT_WRAP_IRQ_ENABLE 2
`define ART_BIT_EF 2
`define ART_BIT_CPF 1
`define ART_BIT_OVF 0
`define ART_MODE_RELOAD 2'b00
`define ART_MODE_CAPTURE 2'b01
`define ART_MODE_CAPRST 2'b10
`define ART_MODE_EXTLOAD 2'b11
`define ART_CLK_INT 2'b00
`define ART_CLK_DIV3 2'b01
`define ART_CLK_PIN 2'b10
`define ART_DIV3_LAST 2'd2
`endif

// >>> verilog/art_timer.v
// Auto-reload timer: prescaler, 8-bit up-counter, capture, compare, PWM and flags.
//
// What this block does
// - Auto-reload accepts internal, divided-by-three, pin clocks.
// - Counter increments on each prescaler output tick.
// - Capture mode copies counter on edge, sets edge_flag.
// - Overflow drives output high, match drives it low.
// - Capture-with-reset clears counter and prescaler.
// - External-load mode loads counter on active edge.
// - Every counter load also clears the prescaler.
// - Writing 06h clears wrap_flag, keeps edge_flag.
// - Reset clears mode control register to 00h.
// - Load bit loads counter, clears prescaler, reads zero.
// - Enable bit cleared freezes prescaler and counter.
// - PWM output enable gates waveform onto pin.
// - Flag with its enable raises an interrupt request.
// - Mode field selects one of four modes.
// - Writing zero clears a flag, one keeps it.
// - Any active input edge sets edge_flag.
// - Counter equal to compare sets match_flag.
// - Counter wrap FFh to 00h sets wrap_flag.
// - Auto-reload overflow reloads counter and sets output.
// - Edge control: low bit enables, high bit picks falling.
// - Clock select: internal, divide by three, pin.
// - Prescaler ratio is two to the field value.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "art_defines.vh"

module art_timer (
    input wire clock,
    input wire rst_b,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire timer_input_pin,
    output reg timer_output_pin,
    output wire edge_irq,
    output wire match_irq,
    output wire wrap_irq
);

    // Software-visible registers. The load register has no storage of its own: a write goes
    // straight into the counter and a read returns the live count.
    reg [7:0] timer_mode_control;
    reg [2:0] timer_status_flags;
    reg [7:0] clock_edge_select_reg;
    reg [7:0] reload_capture_reg;
    reg [7:0] compare_value_reg;

    // Counting state. The counter and the prescaler are always cleared or loaded together.
    reg [7:0] up_counter;
    reg [6:0] clock_prescaler;
    reg [1:0] div3_count;

    // Input pin history: two synchroniser stages and one stage for edge detection.
    reg pin_meta;
    reg pin_sync;
    reg pin_prev;

    // Internal waveform; the pin only shows it while the output enable is set.
    reg wave;

    // Next-state values of the counting and flag logic.
    reg [7:0] next_up_counter;
    reg [6:0] next_clock_prescaler;
    reg [2:0] next_status_flags;

    // Field views of the control registers. Bit 4 of the clock/edge register is reserved and
    // is held at zero. Software must keep the clock selection fixed while counting, because a
    // change in mid-count can leave the counter at an unexpected value; nothing here guards it.
    // The reserved clock selection 11 is accepted but produces no ticks, so the count stops.
    // Compare values below the reload value give a pin that never falls within a period.
    wire [1:0] mode_select_field = timer_mode_control[1:0];
    wire count_enable_bit = timer_mode_control[`ART_BIT_ENABLE];
    wire [1:0] clock_select = clock_edge_select_reg[1:0];
    wire edge_detect_enable = clock_edge_select_reg[2];
    wire edge_polarity_select = clock_edge_select_reg[3];
    wire [2:0] divider_select = clock_edge_select_reg[7:5];

    // Source clock ticks are single-cycle enables, so the whole block stays on one clock.
    wire pin_rise = pin_sync & ~pin_prev;
    wire pin_fall = ~pin_sync & pin_prev;
    reg src_tick;

    // Clock multiplexer; the reserved selection produces no ticks.
    // The pin source uses synchronised rising edges, so a pin clock must stay well below
    // a third of the internal clock or ticks are lost.
    always @* begin
        case (clock_select)
            `ART_CLK_INT: src_tick = 1'b1;
            `ART_CLK_DIV3: src_tick = (div3_count == `ART_DIV3_LAST);
            `ART_CLK_PIN: src_tick = pin_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // Tap selection: a tick every 2^n source ticks, taken when the low n prescaler bits are all ones.
    // Changing the ratio does not touch the prescaler itself, so the first period after a
    // change may be short.
    function tap_hit;
        input [6:0] psc;
        input [2:0] sel;
        reg [6:0] mask;
        begin
            mask = (7'h01 << sel) - 7'h01;
            tap_hit = ((psc & mask) == mask);
        end
    endfunction

    wire count_tick = count_enable_bit & src_tick & tap_hit(clock_prescaler, divider_select);

    // Active edge per the edge-control field. With detection off, the pin neither sets the
    // edge flag nor captures or loads anything.
    wire active_edge = edge_detect_enable & (edge_polarity_select ? pin_fall : pin_rise);

    // Mode-qualified pin events. Both capture modes copy the counter; the resetting one also
    // restarts the count, so the captured value is the time since the previous capture.
    // These events act whether or not counting is enabled.
    wire is_capture = (mode_select_field == `ART_MODE_CAPTURE) || (mode_select_field == `ART_MODE_CAPRST);
    wire capture_evt = active_edge & is_capture;
    wire caprst_evt = active_edge & (mode_select_field == `ART_MODE_CAPRST);
    wire extload_evt = active_edge & (mode_select_field == `ART_MODE_EXTLOAD);

    // Overflow is a counted step out of FFh; a load to FFh alone is not one.
    // Match is flagged on entry into equality, so a frozen counter does not re-arm it.
    wire overflow = count_tick & (up_counter == 8'hff);
    wire match = (up_counter == compare_value_reg);
    reg match_prev;
    wire match_evt = match & ~match_prev;

    // Register select. All write strobes decode the address through this one comparison.
    function reg_hit;
        input [7:0] bus_addr;
        input [7:0] offset;
        begin
            reg_hit = (bus_addr == offset);
        end
    endfunction

    // Write strobes per register; reads are decoded in the read multiplexer.
    wire wr_mode = wr & reg_hit(addr, `ART_ADDR_MODE);
    wire wr_status = wr & reg_hit(addr, `ART_ADDR_STATUS);
    wire wr_clksel = wr & reg_hit(addr, `ART_ADDR_CLKSEL);
    wire wr_reload = wr & reg_hit(addr, `ART_ADDR_RELOAD);
    wire wr_compare = wr & reg_hit(addr, `ART_ADDR_COMPARE);
    wire wr_load = wr & reg_hit(addr, `ART_ADDR_LOAD);
    // The load bit acts only in its write cycle and is never stored.
    wire core_load = wr_mode & wdata[`ART_BIT_LOAD];

    // Pin synchroniser; the first stage feeds only the second.
    // The pin is unrelated to our clock, so no logic may look at the first stage.
    // An extra stage gives the previous value for edge detection.
    always @(posedge clock) begin
        if (!rst_b) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= timer_input_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Divide-by-three counter runs freely from the internal clock.
    // Its phase is not reset by a load, so the first divided tick after a load comes one to
    // three cycles later; this is the price of a divider shared by all modes.
    always @(posedge clock) begin
        if (!rst_b) begin
            div3_count <= 2'd0;
        end else if (div3_count == `ART_DIV3_LAST) begin
            div3_count <= 2'd0;
        end else begin
            div3_count <= div3_count + 2'd1;
        end
    end

    // Next counter and prescaler. Loads are listed in priority order and each clears the
    // prescaler, so counting restarts from a known phase. A software load wins over a
    // simultaneous count, as a write should; a pin load or counter reset in the same cycle is then lost.
    always @* begin
        next_up_counter = up_counter;
        next_clock_prescaler = clock_prescaler;
        if (wr_load) begin
            next_up_counter = wdata;
            next_clock_prescaler = 7'h00;
        end else if (core_load) begin
            next_up_counter = reload_capture_reg;
            next_clock_prescaler = 7'h00;
        end else if (extload_evt) begin
            next_up_counter = reload_capture_reg;
            next_clock_prescaler = 7'h00;
        end else if (caprst_evt) begin
            next_up_counter = 8'h00;
            next_clock_prescaler = 7'h00;
        end else if (overflow && mode_select_field == `ART_MODE_RELOAD) begin
            next_up_counter = reload_capture_reg;
            next_clock_prescaler = 7'h00;
        end else if (count_enable_bit && src_tick) begin
            // With the enable bit clear neither register counts.
            next_clock_prescaler = clock_prescaler + 7'h01;
            if (count_tick) begin
                next_up_counter = up_counter + 8'h01;
            end
        end
    end

    // Counter and prescaler registers.
    always @(posedge clock) begin
        if (!rst_b) begin
            up_counter <= 8'h00;
            clock_prescaler <= 7'h00;
        end else begin
            up_counter <= next_up_counter;
            clock_prescaler <= next_clock_prescaler;
        end
    end

    // Software registers; the load bit is never stored and bit 4 of the clock/edge register
    // stays zero.
    always @(posedge clock) begin
        if (!rst_b) begin
            timer_mode_control <= `ART_MODE_RESET;
            clock_edge_select_reg <= 8'h00;
            compare_value_reg <= 8'h00;
            reload_capture_reg <= 8'h00;
        end else begin
            if (wr_mode) begin
                timer_mode_control <= {1'b0, wdata[6:0]};
            end
            if (wr_clksel) begin
                clock_edge_select_reg <= {wdata[7:5], 1'b0, wdata[3:0]};
            end
            if (wr_compare) begin
                compare_value_reg <= wdata;
            end
            // Capture beats a same-cycle software write so the measurement is kept.
            if (capture_evt) begin
                reload_capture_reg <= up_counter;
            end else if (wr_reload) begin
                reload_capture_reg <= wdata;
            end
        end
    end

    // A flag clears only where software writes a zero over it; a one leaves it as it is.
    // Writing 06h therefore clears the wrap flag alone and keeps the edge flag latched.
    wire clr_edge_flag = wr_status & ~wdata[`ART_BIT_EF];
    wire clr_match_flag = wr_status & ~wdata[`ART_BIT_CPF];
    wire clr_wrap_flag = wr_status & ~wdata[`ART_BIT_OVF];

    // Next flag values: a hardware set in the cycle of a clearing write wins, so no event is lost.
    always @* begin
        next_status_flags = timer_status_flags;
        if (clr_edge_flag) begin
            next_status_flags[`ART_BIT_EF] = 1'b0;
        end
        if (clr_match_flag) begin
            next_status_flags[`ART_BIT_CPF] = 1'b0;
        end
        if (clr_wrap_flag) begin
            next_status_flags[`ART_BIT_OVF] = 1'b0;
        end
        if (active_edge) begin
            next_status_flags[`ART_BIT_EF] = 1'b1;
        end
        if (match_evt) begin
            next_status_flags[`ART_BIT_CPF] = 1'b1;
        end
        if (overflow) begin
            next_status_flags[`ART_BIT_OVF] = 1'b1;
        end
    end

    // Flag register and the match history used to find entry into equality.
    always @(posedge clock) begin
        if (!rst_b) begin
            timer_status_flags <= 3'b000;
            match_prev <= 1'b0;
        end else begin
            timer_status_flags <= next_status_flags;
            match_prev <= match;
        end
    end

    // Waveform: overflow is taken first, so when both fall in one cycle the pulse starts.
    // A compare value below the reload value is never reached and the pin stays high.
    always @(posedge clock) begin
        if (!rst_b) begin
            wave <= 1'b0;
        end else if (overflow) begin
            wave <= 1'b1;
        end else if (match_evt) begin
            wave <= 1'b0;
        end
    end

    // Output pin is held low when disabled while the waveform keeps running.
    // Keeping the waveform alive means that enabling the output shows the current phase at
    // once instead of waiting for the next overflow.
    always @(posedge clock) begin
        if (!rst_b) begin
            timer_output_pin <= 1'b0;
        end else begin
            timer_output_pin <= timer_mode_control[`ART_BIT_PWM_OUTPUT_ENABLE] & wave;
        end
    end

    // Interrupt requests, one per flag. They are levels that stay up until software clears
    // the flag or its enable bit.
    assign edge_irq = timer_mode_control[`ART_BIT_EIE] & timer_status_flags[`ART_BIT_EF];
    assign match_irq = timer_mode_control[`ART_BIT_MATCH_IRQ_ENABLE] & timer_status_flags[`ART_BIT_CPF];
    assign wrap_irq = timer_mode_control[`ART_BIT_WRAP_IRQ_ENABLE] & timer_status_flags[`ART_BIT_OVF];

    // Read data, one cycle after the strobe; the load register reads the live counter.
    // Unmapped addresses and idle cycles give zero, so the bus shows nothing stale.
    // The prescaler read is a convenience for software that times short intervals.
    always @(posedge clock) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `ART_ADDR_PRESCALE: rdata <= {1'b0, clock_prescaler};
                `ART_ADDR_MODE: rdata <= {1'b0, timer_mode_control[6:0]};
                `ART_ADDR_STATUS: rdata <= {5'h00, timer_status_flags};
                `ART_ADDR_CLKSEL: rdata <= clock_edge_select_reg;
                `ART_ADDR_RELOAD: rdata <= reload_capture_reg;
                `ART_ADDR_COMPARE: rdata <= compare_value_reg;
                `ART_ADDR_LOAD: rdata <= up_counter;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

// >>> tb/art_properties.sv
// Port-level assertions of the auto-reload timer.
`timescale 1ns/1ps
module art_checker (
    input wire clock,
    input wire rst_b,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire timer_input_pin,
    input wire timer_output_pin,
    input wire edge_irq,
    input wire match_irq,
    input wire wrap_irq
);
    reg [7:0] mode;
    reg [7:0] csel;
    // Shadows of what software last wrote; the load bit never sticks, so it is dropped.
    always @(posedge clock) mode <= !rst_b ? 8'h00 : (wr && addr == 8'hd5) ? {1'b0, wdata[6:0]} : mode;
    always @(posedge clock) csel <= !rst_b ? 8'h00 : (wr && addr == 8'hd7) ? wdata : csel;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Enabled, auto-reload, undivided internal clock: the count steps once per cycle.
    sequence s_count_rd; rd && addr == 8'hdb && mode[6] && mode[1:0] == 2'b00 && csel == 8'h00; endsequence
    sequence s_frozen_wr; wr && addr == 8'hdb && !mode[6] && !mode[1]; endsequence
    property p_mode_read; rd && addr == 8'hd5 |=> rdata == $past(mode); endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read");
    property p_status_read;
        rd && addr == 8'hd6 |=> rdata[7:3] == 5'h00 && (($past(mode) & 8'h04) == 8'h00 || rdata[0] == $past(wrap_irq));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read");
    property p_pwm_off; (($past(mode) | mode) & 8'h20) == 8'h00 |-> !timer_output_pin; endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("pin not low");
    property p_edge_en; edge_irq |-> mode[4]; endproperty
    a_edge_en: assert property (p_edge_en) else $error("edge request unmasked");
    property p_match_en; match_irq |-> mode[3]; endproperty
    a_match_en: assert property (p_match_en) else $error("match request unmasked");
    property p_wrap_en; wrap_irq |-> mode[2]; endproperty
    a_wrap_en: assert property (p_wrap_en) else $error("wrap request unmasked");
    property p_keep_edge; wr && addr == 8'hd6 && wdata == 8'h06 && edge_irq |=> edge_irq; endproperty
    a_keep_edge: assert property (p_keep_edge) else $error("edge flag lost");
    property p_load_read; s_frozen_wr ##1 (rd && addr == 8'hdb) |=> rdata == $past(wdata, 2); endproperty
    a_load_read: assert property (p_load_read) else $error("load readback");
    property p_count_step; s_count_rd ##1 s_count_rd |=> rdata == $past(rdata) + 8'h01 || $past(rdata) == 8'hff; endproperty
    a_count_step: assert property (p_count_step) else $error("count step");
endmodule
bind art_timer art_checker i_art_checker (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
    .edge_irq(edge_irq), .match_irq(match_irq), .wrap_irq(wrap_irq));

// >>> tb/art_edge_src.sv
// External edge source that drives the timer input pin.
`timescale 1ns/1ps
module art_edge_src (
    input wire clock,
    input wire go,
    output reg pin
);
    initial pin = 1'b0;
    // The pin moves 3 ns after the edge, since the real source is unrelated to our clock.
    always @(posedge clock) begin
        if (go) pin <= #3 ~pin;
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench of the auto-reload timer.
`timescale 1ns/1ps
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg go = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg [7:0] seed = 8'h4a;
    reg [7:0] d1;
    reg [7:0] d2;
    integer failures = 0;
    integer cmp_count = 0;
    integer i;
    wire [7:0] rdata;
    wire pin_in, pin_out, edge_irq, match_irq, wrap_irq;
    always #5 clock = ~clock;
    art_timer i_art_timer (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_input_pin(pin_in), .timer_output_pin(pin_out), .edge_irq(edge_irq),
        .match_irq(match_irq), .wrap_irq(wrap_irq));
    art_edge_src i_art_edge_src (.clock(clock), .go(go), .pin(pin_in));
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Steps in 24 cycles: bit 2 picks the divide-by-three source, bits 1-0 the prescaler.
    function [7:0] ticks(input [2:0] n);
        ticks = 8'd24 / ((n[2] ? 8'd3 : 8'd1) << n[1:0]);
    endfunction
    task idle(input integer n);
        begin
            wr <= 1'b0;
            rd <= 1'b0;
            go <= 1'b0;
            repeat (n) @(posedge clock);
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            rd <= 1'b0;
            @(posedge clock);
        end
    endtask
    // Read data stand in the cycle after the strobe and are taken in its middle.
    task rd_reg(input [7:0] a, output [7:0] d);
        begin
            addr <= a;
            wr <= 1'b0;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            @(negedge clock);
            d = rdata;
            @(posedge clock);
        end
    endtask
    // One pin toggle; synchroniser and edge detector need three cycles, eight are given.
    task pulse;
        begin
            wr <= 1'b0;
            go <= 1'b1;
            @(posedge clock);
            idle(8);
        end
    endtask
    task conclude;
        begin
            $display("Comparisons %0d, failures %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        idle(20);
        rst_b <= 1'b1;
        wr_reg(8'hd4, 8'hff);
        rd_reg(8'hd5, d1);
        `CHECK(d1, 8'h00)
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            wr_reg(8'hd5, seed);
            rd_reg(8'hd5, d1);
            `CHECK(d1, {1'b0, seed[6:0]})
        end
        wr_reg(8'hd5, 8'h00);
        wr_reg(8'hd6, 8'h00);
        wr_reg(8'hd7, 8'h00);
        wr_reg(8'hd9, 8'h20);
        wr_reg(8'hda, 8'h30);
        wr_reg(8'hd5, 8'hf4);
        addr <= 8'hdb;
        wr <= 1'b0;
        rd <= 1'b1;
        // Two reads back to back; each value is taken mid-cycle while it stands.
        @(posedge clock);
        @(negedge clock);
        d1 = rdata;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        `CHECK({d1, rdata - d1}, 16'h2001)
        @(posedge clock);
        wr_reg(8'hdb, 8'hfe);
        wr <= 1'b0;
        for (i = 0; i < 10 && wrap_irq !== 1'b1; i = i + 1) @(negedge clock);
        if (i == 10) begin
            failures++;
            conclude;
        end
        repeat (2) @(negedge clock);
        `CHECK(pin_out, 1'b1)
        repeat (20) @(negedge clock);
        `CHECK(pin_out, 1'b0)
        @(posedge clock);
        rd_reg(8'hd6, d1);
        `CHECK(d1, 8'h03)
        `CHECK(match_irq, 1'b0)
        wr_reg(8'hd7, 8'h04);
        pulse;
        `CHECK(edge_irq, 1'b1)
        wr_reg(8'hd6, 8'h06);
        idle(1);
        `CHECK({edge_irq, wrap_irq}, 2'b10)
        wr_reg(8'hd6, 8'h00);
        idle(1);
        `CHECK(edge_irq, 1'b0)
        wr_reg(8'hd5, 8'h11);
        wr_reg(8'hd7, 8'h0c);
        wr_reg(8'hdb, 8'h77);
        rd_reg(8'hdb, d1);
        `CHECK(d1, 8'h77)
        pulse;
        rd_reg(8'hd9, d1);
        `CHECK({d1, edge_irq}, 9'h0ef)
        wr_reg(8'hd5, 8'h03);
        wr_reg(8'hd7, 8'h04);
        wr_reg(8'hd9, 8'h99);
        pulse;
        rd_reg(8'hdb, d1);
        `CHECK(d1, 8'h99)
        wr_reg(8'hd5, 8'h02);
        wr_reg(8'hd7, 8'h0c);
        wr_reg(8'hdb, 8'h33);
        pulse;
        rd_reg(8'hd9, d1);
        rd_reg(8'hdb, d2);
        `CHECK({d1, d2}, 16'h3300)
        for (i = 0; i < 8; i = i + 1) begin
            wr_reg(8'hd5, 8'h00);
            wr_reg(8'hd7, {1'b0, i[1:0], 4'h0, i[2]});
            wr_reg(8'hd5, 8'hc0);
            rd_reg(8'hdb, d1);
            idle(22);
            rd_reg(8'hdb, d2);
            `CHECK(d2 - d1, ticks(i[2:0]))
        end
        conclude;
    end
endmodule
